// ### fc_ls_target.sv
`timescale 1ns/1ps
// Overview of operation
// - BLS: no payload, TYPE 00h, R_CTL 1000xxxx
// - Decode NOP, ABTS, RMC, BA_ACC, BA_RJT
// - NOP and RMC discarded silently
// - Reserved and invalid fields never checked
// - One BA_ACC or BA_RJT per ABTS
// - Initiator aborts whole exchanges only
// - BA_ACC payload twelve bytes, fixed layout
// - SEQ_ID validity and SEQ_ID zero
// - OX_ID, RX_ID from aborted exchange
// - Both sequence counts zero
// - BA_RJT payload four bytes
// - BA_RJT reason code encodings
// - BA_RJT explanation encodings
// - ELS TYPE 01h, R_CTL 22h/23h
// - First payload byte is command code
// - Fourteen supported ELS request codes
// - Code 11h split by second byte
// - Loop frame types 01h to 07h
// - Loop frame outside init gets LS_RJT
// - Unsupported ELS gets LS_RJT
// - LS_RJT payload layout, word 01000000h
// - Not supported 0Bh, explanation 00h
module fc_ls_target (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	fc_ls_if.target link,
	input wire logic loop_init_i,
	input wire logic abort_busy_i,
	output logic els_req_o,
	output logic [7:0] els_code_o,
	output logic loop_frame_o,
	output logic [7:0] loop_kind_o
);
	fc_ls_pkg::reply_kind_t kind;
	logic is_abts;
	logic take;
	logic busy;

	logic abts_open;
	logic next_ready;
	logic next_answer;
	logic [7:0] next_r_ctl;
	logic [7:0] next_type;
	logic [3:0] next_len;
	logic [8*fc_ls_pkg::MAX_LEN-1:0] next_payload;

	// ****************************************
	// Frame classification
	// ****************************************
	fc_ls_classify u_cls (
		.r_ctl_i(link.rq_r_ctl),
		.type_i(link.rq_type),
		.pl0_i(link.rq_pl0),
		.pl1_i(link.rq_pl1),
		.pl_present_i(link.rq_pl_present),
		.loop_init_i(loop_init_i),
		.abts_pending_i(abort_busy_i),
		.kind_o(kind),
		.is_abts_o(is_abts)
	);

	// ****************************************
	// Request acceptance
	// ****************************************
	assign busy = link.rp_valid;
	assign take = link.rq_valid && link.rq_ready;

	// Closed while a reply is owed or on the wire
	always_comb begin
		next_ready = 1'b1;
		if (busy || abts_open)
			next_ready = 1'b0;
		if (take && next_answer)
			next_ready = 1'b0;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			link.rq_ready <= 1'b0;
		else
			link.rq_ready <= next_ready;
	end

	// ****************************************
	// Outstanding ABTS
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			abts_open <= 1'b0;
		else if (take && is_abts)
			abts_open <= 1'b1;
		else if (link.rp_valid && link.rp_ready)
			abts_open <= 1'b0;
	end

	// ****************************************
	// Reply frame contents
	// ****************************************
	// Built from the request being taken this cycle
	always_comb begin
		next_answer = 1'b0;
		next_r_ctl = 8'h00;
		next_type = 8'h00;
		next_len = 4'h0;
		next_payload = '0;
		case (kind)
			fc_ls_pkg::RPY_BA_ACC: begin
				next_answer = is_abts;
				next_type = fc_ls_pkg::TYPE_BLS;
				next_r_ctl = {fc_ls_pkg::RCTL_BLS_HI, fc_ls_pkg::BLS_ACC};
				next_len = 4'(fc_ls_pkg::BAACC_LEN);
				next_payload = {fc_ls_pkg::SEQID_INVALID, 8'h00, fc_ls_pkg::RSVD_BYTE,
					fc_ls_pkg::RSVD_BYTE, link.rq_ox_id, link.rq_rx_id,
					fc_ls_pkg::SEQ_CNT_ZERO, fc_ls_pkg::SEQ_CNT_ZERO};
			end
			fc_ls_pkg::RPY_BA_RJT: begin
				next_answer = is_abts;
				next_type = fc_ls_pkg::TYPE_BLS;
				next_r_ctl = {fc_ls_pkg::RCTL_BLS_HI, fc_ls_pkg::BLS_RJT};
				next_len = 4'(fc_ls_pkg::BARJT_LEN);
				next_payload = {fc_ls_pkg::RSVD_BYTE, fc_ls_pkg::BRJT_LOGICAL_BUSY,
					fc_ls_pkg::BEXP_NONE, fc_ls_pkg::VENDOR_BYTE, 64'h0};
			end
			fc_ls_pkg::RPY_LS_RJT: begin
				next_answer = 1'b1;
				next_type = fc_ls_pkg::TYPE_ELS;
				next_r_ctl = fc_ls_pkg::RCTL_ELS_RPY;
				next_len = 4'(fc_ls_pkg::LSRJT_LEN);
				next_payload = {fc_ls_pkg::LSRJT_WORD0, fc_ls_pkg::RSVD_BYTE,
					fc_ls_pkg::LSRJT_NOT_SUPP, fc_ls_pkg::LSRJT_EXP_NONE,
					fc_ls_pkg::VENDOR_BYTE, 32'h0};
			end
			default: next_answer = 1'b0;
		endcase
	end

	// ****************************************
	// Reply handshake
	// ****************************************
	// Held until the initiator takes it
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			link.rp_valid <= 1'b0;
		else if (link.rp_valid && link.rp_ready)
			link.rp_valid <= 1'b0;
		else if (take)
			link.rp_valid <= next_answer;
	end

	// ****************************************
	// Reply header and payload
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			link.rp_r_ctl <= 8'h00;
			link.rp_type <= 8'h00;
			link.rp_ox_id <= 16'h0000;
			link.rp_rx_id <= 16'h0000;
			link.rp_len <= 4'h0;
		end else if (take && next_answer) begin
			link.rp_r_ctl <= next_r_ctl;
			link.rp_type <= next_type;
			link.rp_ox_id <= link.rq_ox_id;
			link.rp_rx_id <= link.rq_rx_id;
			link.rp_len <= next_len;
		end
	end

	// Unused low bytes stay zero
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			link.rp_payload <= '0;
		else if (take && next_answer)
			link.rp_payload <= next_payload;
	end

	// ****************************************
	// Supported request forwarding
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			els_req_o <= 1'b0;
			els_code_o <= 8'h00;
		end else begin
			els_req_o <= take && kind == fc_ls_pkg::RPY_ELS_PASS;
			if (take)
				els_code_o <= link.rq_pl0;
		end
	end

	// ****************************************
	// Loop frame forwarding
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			loop_frame_o <= 1'b0;
			loop_kind_o <= 8'h00;
		end else begin
			loop_frame_o <= take && kind == fc_ls_pkg::RPY_NONE && link.rq_type == fc_ls_pkg::TYPE_ELS &&
				link.rq_r_ctl == fc_ls_pkg::RCTL_ELS_REQ;
			if (take)
				loop_kind_o <= link.rq_pl1;
		end
	end
endmodule : fc_ls_target

// ### fc_ls_pkg.sv
package fc_ls_pkg;
	// ****************************************
	// Header codes
	// ****************************************
	localparam logic [7:0] TYPE_BLS = 8'h00;
	localparam logic [7:0] TYPE_ELS = 8'h01;
	localparam logic [3:0] RCTL_BLS_HI = 4'h8;
	localparam logic [7:0] RCTL_ELS_REQ = 8'h22;
	localparam logic [7:0] RCTL_ELS_RPY = 8'h23;
	localparam int FCTL_PARAM_VALID_BIT = 3;
	// ****************************************
	// Basic link service codes
	// ****************************************
	localparam logic [3:0] BLS_NOP = 4'h0;
	localparam logic [3:0] BLS_ABTS = 4'h1;
	localparam logic [3:0] BLS_RMC = 4'h2;
	localparam logic [3:0] BLS_ACC = 4'h4;
	localparam logic [3:0] BLS_RJT = 4'h5;
	localparam logic [7:0] SEQID_VALID = 8'h80;
	localparam logic [7:0] SEQID_INVALID = 8'h00;
	localparam logic [15:0] SEQ_CNT_ZERO = 16'h0000;
	localparam logic [7:0] BRJT_INVALID_CMD = 8'h01;
	localparam logic [7:0] BRJT_LOGICAL_ERR = 8'h03;
	localparam logic [7:0] BRJT_LOGICAL_BUSY = 8'h05;
	localparam logic [7:0] BRJT_PROTOCOL_ERR = 8'h07;
	localparam logic [7:0] BRJT_UNABLE = 8'h09;
	localparam logic [7:0] BRJT_VENDOR = 8'hff;
	localparam logic [7:0] BEXP_NONE = 8'h00;
	localparam logic [7:0] BEXP_BAD_IDS = 8'h03;
	localparam logic [7:0] BEXP_NO_SEQ_INFO = 8'h05;
	// ****************************************
	// Extended link service codes
	// ****************************************
	localparam logic [7:0] ELS_RJT = 8'h01;
	localparam logic [7:0] ELS_ACC = 8'h02;
	localparam logic [7:0] ELS_LOOP_TEST = 8'h11;
	localparam int NUM_ELS = 14;
	localparam logic [NUM_ELS*8-1:0] ELS_LIST = {8'h52, 8'h60, 8'h04, 8'h05, 8'h50, 8'h03, 8'h20,
		8'h21, 8'h0f, 8'h53, 8'h78, 8'h12, 8'h24, 8'h7d};
	localparam logic [7:0] LOOP_FIRST = 8'h01;
	localparam logic [7:0] LOOP_LAST = 8'h07;
	localparam logic [31:0] LSRJT_WORD0 = 32'h01000000;
	localparam logic [7:0] LSRJT_NOT_SUPP = 8'h0b;
	localparam logic [7:0] LSRJT_EXP_NONE = 8'h00;
	localparam logic [7:0] VENDOR_BYTE = 8'h00;
	localparam logic [7:0] RSVD_BYTE = 8'h00;
	// ****************************************
	// Payload bytes of replies
	// ****************************************
	localparam int BAACC_LEN = 12;
	localparam int BARJT_LEN = 4;
	localparam int LSRJT_LEN = 8;
	localparam int MAX_LEN = 12;

	typedef enum logic [2:0] {
		RPY_NONE,
		RPY_BA_ACC,
		RPY_BA_RJT,
		RPY_LS_RJT,
		RPY_ELS_PASS
	} reply_kind_t;
endpackage : fc_ls_pkg

// ### fc_ls_if.sv
`timescale 1ns/1ps
interface fc_ls_if;
	// Initiator to target frame
	logic rq_valid;
	logic rq_ready;
	logic [7:0] rq_r_ctl;
	logic [7:0] rq_type;
	logic [23:0] rq_f_ctl;
	logic [15:0] rq_ox_id;
	logic [15:0] rq_rx_id;
	logic [31:0] rq_param;
	logic [7:0] rq_pl0;
	logic [7:0] rq_pl1;
	logic rq_pl_present;
	// Target to initiator frame
	logic rp_valid;
	logic rp_ready;
	logic [7:0] rp_r_ctl;
	logic [7:0] rp_type;
	logic [15:0] rp_ox_id;
	logic [15:0] rp_rx_id;
	logic [3:0] rp_len;
	logic [8*fc_ls_pkg::MAX_LEN-1:0] rp_payload;

	modport target (
		input rq_valid, rq_r_ctl, rq_type, rq_f_ctl, rq_ox_id, rq_rx_id, rq_param, rq_pl0, rq_pl1,
		input rq_pl_present, rp_ready,
		output rq_ready, rp_valid, rp_r_ctl, rp_type, rp_ox_id, rp_rx_id, rp_len, rp_payload
	);
	modport initiator (
		output rq_valid, rq_r_ctl, rq_type, rq_f_ctl, rq_ox_id, rq_rx_id, rq_param, rq_pl0, rq_pl1,
		output rq_pl_present, rp_ready,
		input rq_ready, rp_valid, rp_r_ctl, rp_type, rp_ox_id, rp_rx_id, rp_len, rp_payload
	);
endinterface : fc_ls_if

// ### fc_ls_classify.sv
`timescale 1ns/1ps
module fc_ls_classify (
	input wire logic [7:0] r_ctl_i,
	input wire logic [7:0] type_i,
	input wire logic [7:0] pl0_i,
	input wire logic [7:0] pl1_i,
	input wire logic pl_present_i,
	input wire logic loop_init_i,
	input wire logic abts_pending_i,
	output fc_ls_pkg::reply_kind_t kind_o,
	output logic is_abts_o
);
	logic els_known;
	logic [fc_ls_pkg::NUM_ELS-1:0] hit;
	logic loop_frame;

	// ****************************************
	// Supported request lookup
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < fc_ls_pkg::NUM_ELS; g++) begin : g_els
			assign hit[g] = (pl0_i == fc_ls_pkg::ELS_LIST[g*8 +: 8]);
		end
	endgenerate
	assign els_known = |hit;
	assign loop_frame = (pl0_i == fc_ls_pkg::ELS_LOOP_TEST) && (pl1_i >= fc_ls_pkg::LOOP_FIRST) &&
		(pl1_i <= fc_ls_pkg::LOOP_LAST);

	always_comb begin
		kind_o = fc_ls_pkg::RPY_NONE;
		is_abts_o = 1'b0;
		// Parameter word and reserved fields never examined
		if (type_i == fc_ls_pkg::TYPE_BLS && r_ctl_i[7:4] == fc_ls_pkg::RCTL_BLS_HI && !pl_present_i) begin
			case (r_ctl_i[3:0])
				fc_ls_pkg::BLS_ABTS: begin
					is_abts_o = 1'b1;
					kind_o = abts_pending_i ? fc_ls_pkg::RPY_BA_RJT : fc_ls_pkg::RPY_BA_ACC;
				end
				fc_ls_pkg::BLS_NOP, fc_ls_pkg::BLS_RMC: kind_o = fc_ls_pkg::RPY_NONE;
				fc_ls_pkg::BLS_ACC, fc_ls_pkg::BLS_RJT: kind_o = fc_ls_pkg::RPY_NONE;
				default: kind_o = fc_ls_pkg::RPY_NONE;
			endcase
		end else if (type_i == fc_ls_pkg::TYPE_ELS && r_ctl_i == fc_ls_pkg::RCTL_ELS_REQ) begin
			if (els_known)
				kind_o = fc_ls_pkg::RPY_ELS_PASS;
			else if (loop_frame && loop_init_i)
				kind_o = fc_ls_pkg::RPY_NONE;
			else
				kind_o = fc_ls_pkg::RPY_LS_RJT;
		end
	end
endmodule : fc_ls_classify

// ### fc_ls_initiator.sv
`timescale 1ns/1ps
module fc_ls_initiator (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	fc_ls_if.initiator link,
	input wire logic send_i,
	input wire logic [7:0] r_ctl_i,
	input wire logic [7:0] type_i,
	input wire logic [15:0] ox_id_i,
	input wire logic [15:0] rx_id_i,
	input wire logic [7:0] pl0_i,
	input wire logic [7:0] pl1_i,
	input wire logic pl_present_i,
	output logic busy_o,
	output logic reply_o,
	output logic [7:0] reply_r_ctl_o,
	output logic [8*fc_ls_pkg::MAX_LEN-1:0] reply_payload_o
);
	// ****************************************
	// Request launch
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			link.rq_valid <= 1'b0;
			link.rq_r_ctl <= 8'h00;
			link.rq_type <= 8'h00;
			link.rq_f_ctl <= 24'h000000;
			link.rq_ox_id <= 16'h0000;
			link.rq_rx_id <= 16'h0000;
			link.rq_param <= 32'h00000000;
			link.rq_pl0 <= 8'h00;
			link.rq_pl1 <= 8'h00;
			link.rq_pl_present <= 1'b0;
		end else if (link.rq_valid && link.rq_ready) begin
			link.rq_valid <= 1'b0;
		end else if (send_i && !link.rq_valid) begin
			// ABTS always aborts the whole exchange
			link.rq_valid <= 1'b1;
			link.rq_r_ctl <= r_ctl_i;
			link.rq_type <= type_i;
			link.rq_ox_id <= ox_id_i;
			link.rq_rx_id <= rx_id_i;
			link.rq_pl0 <= pl0_i;
			link.rq_pl1 <= pl1_i;
			link.rq_pl_present <= pl_present_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			busy_o <= 1'b0;
		else
			busy_o <= link.rq_valid && !link.rq_ready || send_i;
	end

	// ****************************************
	// Reply capture
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			link.rp_ready <= 1'b0;
			reply_o <= 1'b0;
			reply_r_ctl_o <= 8'h00;
			reply_payload_o <= '0;
		end else begin
			link.rp_ready <= 1'b1;
			reply_o <= link.rp_valid && link.rp_ready;
			if (link.rp_valid && link.rp_ready) begin
				reply_r_ctl_o <= link.rp_r_ctl;
				reply_payload_o <= link.rp_payload;
			end
		end
	end
endmodule : fc_ls_initiator

// ### fc_ls_assertions.sv
`timescale 1ns/1ps
module fc_ls_assertions (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic rq_valid,
	input wire logic rq_ready,
	input wire logic [7:0] rq_r_ctl,
	input wire logic [7:0] rq_type,
	input wire logic [15:0] rq_ox_id,
	input wire logic [15:0] rq_rx_id,
	input wire logic [7:0] rq_pl0,
	input wire logic rq_pl_present,
	input wire logic rp_valid,
	input wire logic rp_ready,
	input wire logic [7:0] rp_r_ctl,
	input wire logic [7:0] rp_type,
	input wire logic [15:0] rp_ox_id,
	input wire logic [15:0] rp_rx_id,
	input wire logic [3:0] rp_len,
	input wire logic [8*fc_ls_pkg::MAX_LEN-1:0] rp_payload
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	logic take;
	logic bls_take;
	logic els_take;
	logic supp;
	logic abts_take;
	assign take = rq_valid && rq_ready;
	assign abts_take = bls_take && rq_r_ctl[3:0] == 4'h1;
	assign bls_take = take && rq_type == 8'h00 && rq_r_ctl[7:4] == 4'h8 && !rq_pl_present;
	assign els_take = take && rq_type == 8'h01 && rq_r_ctl == 8'h22 && rq_pl_present;
	assign supp = rq_pl0 inside {8'h52, 8'h60, 8'h04, 8'h05, 8'h50, 8'h03, 8'h20, 8'h21, 8'h0f, 8'h53, 8'h78,
		8'h12, 8'h24, 8'h7d};
	abts_answered_a: assert property (abts_take |=> rp_valid && rp_type == 8'h00 &&
		(rp_r_ctl == 8'h84 || rp_r_ctl == 8'h85) && rp_ox_id == $past(rq_ox_id) && rp_rx_id == $past(rq_rx_id))
		else $error("ABTS not answered");
	acc_payload_a: assert property (rp_valid && rp_r_ctl == 8'h84 |-> rp_len == 4'hc &&
		rp_payload == {32'h0, rp_ox_id, rp_rx_id, 32'h0}) else $error("BA_ACC payload wrong");
	acc_after_abts_a: assert property ($rose(rp_valid) && rp_r_ctl == 8'h84 |->
		$past(abts_take)) else $error("BA_ACC without ABTS");
	rjt_payload_a: assert property (rp_valid && rp_r_ctl == 8'h85 |-> rp_len == 4'h4 &&
		rp_payload[95:88] == 8'h00 && rp_payload[79:0] == 80'h0 &&
		rp_payload[87:80] inside {8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'hff}) else $error("BA_RJT payload wrong");
	bls_silent_a: assert property (bls_take && rq_r_ctl[3:0] != 4'h1 |=> !rp_valid)
		else $error("BLS frame answered");
	els_supported_a: assert property (els_take && supp |=> !rp_valid) else $error("Supported ELS rejected");
	els_reject_a: assert property (els_take && !supp && rq_pl0 != 8'h11 |=> rp_valid && rp_type == 8'h01 &&
		rp_r_ctl == 8'h23 && rp_len == 4'h8 && rp_payload[95:32] == 64'h01000000_000b0000)
		else $error("LS_RJT wrong");
	reply_holds_a: assert property (rp_valid && !rp_ready |=> rp_valid && $stable(rp_payload) && $stable(rp_r_ctl))
		else $error("Reply dropped early");
	refuse_busy_a: assert property (rp_valid |-> !rq_ready) else $error("Request taken during reply");
endmodule : fc_ls_assertions

// ### tb_fc_link_service_responder.sv
`timescale 1ns/1ps
module tb_fc_link_service_responder;
	localparam logic [95:0] LSRJT = 96'h01000000_000b0000_00000000;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic send = 1'b0, pp = 1'b0, abort_busy = 1'b0, loop_init = 1'b0;
	logic [7:0] r_ctl = 8'h00, typ = 8'h00, pl0 = 8'h00, pl1 = 8'h00, seq = 8'h00;
	logic [15:0] ox = 16'h0000, rx = 16'h0000;
	logic busy, reply, els_req, loop_frame;
	logic [7:0] reply_r_ctl, els_code, loop_kind;
	logic [95:0] reply_payload;
	logic [7:0] n_reply = 8'h00, n_els = 8'h00, n_loop = 8'h00;
	int n_mismatch = 0, tests_run = 0, cycles = 0, c;
	fc_ls_if link();
	fc_ls_target i_fc_ls_target (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link(link), .loop_init_i(loop_init),
		.abort_busy_i(abort_busy), .els_req_o(els_req), .els_code_o(els_code), .loop_frame_o(loop_frame),
		.loop_kind_o(loop_kind));
	fc_ls_initiator i_fc_ls_initiator (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link(link), .send_i(send),
		.r_ctl_i(r_ctl), .type_i(typ), .ox_id_i(ox), .rx_id_i(rx), .pl0_i(pl0), .pl1_i(pl1), .pl_present_i(pp),
		.busy_o(busy), .reply_o(reply), .reply_r_ctl_o(reply_r_ctl), .reply_payload_o(reply_payload));
	fc_ls_assertions i_fc_ls_assertions (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .rq_valid(link.rq_valid),
		.rq_ready(link.rq_ready), .rq_r_ctl(link.rq_r_ctl), .rq_type(link.rq_type), .rq_ox_id(link.rq_ox_id),
		.rq_rx_id(link.rq_rx_id), .rq_pl0(link.rq_pl0), .rq_pl_present(link.rq_pl_present), .rp_valid(link.rp_valid),
		.rp_ready(link.rp_ready), .rp_r_ctl(link.rp_r_ctl), .rp_type(link.rp_type), .rp_ox_id(link.rp_ox_id),
		.rp_rx_id(link.rp_rx_id), .rp_len(link.rp_len), .rp_payload(link.rp_payload));
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		n_reply <= n_reply + (reply === 1'b1);
		n_els <= n_els + (els_req === 1'b1);
		n_loop <= n_loop + (loop_frame === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Kind k: 0 silent, 1 reply, 2 supported ELS, 3 loop frame
	task frame(input logic [7:0] rc, input logic [7:0] ty, input logic [7:0] p0, input logic [7:0] p1,
		input logic pr, input logic ab, input logic li, input int k, input logic [7:0] erc, input logic [95:0] epl);
		logic [7:0] r0, e0, l0;
		r0 = n_reply;
		e0 = n_els;
		l0 = n_loop;
		seq = seq + 8'h01;
		@(posedge clk_sys_i);
		send <= 1'b1;
		{r_ctl, typ, pl0, pl1, pp, abort_busy, loop_init} <= {rc, ty, p0, p1, pr, ab, li};
		ox <= {8'h1a, seq};
		rx <= {seq, 8'hc3};
		@(posedge clk_sys_i);
		send <= 1'b0;
		@(negedge clk_sys_i);
		for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk_sys_i);
		repeat (4) @(negedge clk_sys_i);
		check("reply count", n_reply - r0, k == 1);
		check("els count", n_els - e0, k == 2);
		check("loop count", n_loop - l0, k == 3);
		if (k == 1) begin
			check("reply r_ctl", reply_r_ctl, erc);
			check("payload", reply_payload, erc == 8'h84 ? {32'h0, ox, rx, 32'h0} : epl);
		end
		if (k == 2) check("els code", els_code, p0);
		if (k == 3) check("loop kind", loop_kind, p1);
	endtask : frame
	task finish_test;
		if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (12) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		frame(8'h81, 8'h00, 0, 0, 0, 0, 0, 1, 8'h84, 0);
		frame(8'h81, 8'h00, 0, 0, 0, 1, 0, 1, 8'h85, {32'h00050000, 64'h0});
		for (c = 0; c < 16; c++) if (c != 1) frame({4'h8, c[3:0]}, 8'h00, 0, 0, 0, 0, 0, 0, 0, 0);
		for (c = 0; c < 14; c++) frame(8'h22, 8'h01, fc_ls_pkg::ELS_LIST[(13-c)*8 +: 8], 0, 1, 0, 0, 2, 0, 0);
		frame(8'h22, 8'h01, 8'h00, 0, 1, 0, 0, 1, 8'h23, LSRJT);
		frame(8'h22, 8'h01, 8'h06, 0, 1, 0, 0, 1, 8'h23, LSRJT);
		frame(8'h22, 8'h01, 8'hff, 0, 1, 0, 0, 1, 8'h23, LSRJT);
		for (c = 1; c < 8; c++) begin
			frame(8'h22, 8'h01, 8'h11, c[7:0], 1, 0, 1, 3, 0, 0);
			frame(8'h22, 8'h01, 8'h11, c[7:0], 1, 0, 0, 1, 8'h23, LSRJT);
		end
		frame(8'h22, 8'h01, 8'h11, 8'h08, 1, 0, 1, 1, 8'h23, LSRJT);
		finish_test();
	end
endmodule : tb_fc_link_service_responder
